// >>> rmlc_defs.vh
// register map lock and checksum constants
// assumes inclusion by the lock block; the map memory takes its sizes as parameters instead
`ifndef RMLC_DEFS_VH
`define RMLC_DEFS_VH
`define RMLC_ADDR_W        5
`define RMLC_DATA_W        24
`define RMLC_SEC_ADDR      5'h1f
`define RMLC_KEY_HI        23
`define RMLC_KEY_LO        16
`define RMLC_SUM_HI        15
`define RMLC_SUM_LO        0
`define RMLC_KEY_UNLOCK    8'ha5
`define RMLC_SUM_RESET     16'h0000
`define RMLC_CRC_POLY      16'h8005
`define RMLC_CRC_SEED      16'h0000
`define RMLC_SUM_PERIOD    21
`define RMLC_SUM_FIRST     5'h00
`define RMLC_SUM_LAST      5'h1e
`endif

// >>> rmlc_map_mem.v
// register storage for the writable part of the map, 31 words of 24 bits
// assumes one write and two registered reads per clock; contents clear at reset
`timescale 1ns/1ps
module rmlc_map_mem #(
  parameter AW    = 5,
  parameter DW    = 24,
  parameter DEPTH = 31
) (
  input  wire          clk_in,
  input  wire          rst_n_in,
  input  wire          wr_en_in,
  input  wire [AW-1:0] wr_addr_in,
  input  wire [DW-1:0] wr_data_in,
  input  wire [AW-1:0] rd_addr_in,
  output reg  [DW-1:0] rd_data_out,
  input  wire [AW-1:0] scan_addr_in,
  output reg  [DW-1:0] scan_data_out
);
  reg [DW-1:0] mem_q [0:DEPTH-1];
  integer i;

  // storage write and registered read ports
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (i = 0; i < DEPTH; i = i + 1)
        mem_q[i] <= {DW{1'b0}};
      rd_data_out   <= {DW{1'b0}};
      scan_data_out <= {DW{1'b0}};
    end
    else
    begin
      if (wr_en_in && (wr_addr_in < DEPTH))
        mem_q[wr_addr_in] <= wr_data_in;
      rd_data_out   <= (rd_addr_in < DEPTH) ? mem_q[rd_addr_in] : {DW{1'b0}};
      scan_data_out <= (scan_addr_in < DEPTH) ? mem_q[scan_addr_in] : {DW{1'b0}};
    end
  end
endmodule

// >>> rmlc_lock.v
// register map lock with 8-bit key and continuous 16-bit map checksum
// assumes a serial front end that gives one-cycle write and read strobes
// Operation
// [R01] the security word holds the key in bits 23..16 and the checksum in 15..0.
// [R02] with the key at a5, its reset value, every register takes writes.
// [R03] with the key at a5 the checksum reads 0000 and the checksum interrupt is cleared.
// [R04] with the key at a5 no checksum is computed.
// [R05] with any other key only the security register takes writes.
// [R06] while locked, reads of other registers return undefined contents.
// [R07] while locked the checksum runs without stop and raises its interrupt only if enabled.
// [R08] the host unlocks with a5 before writing any other register.
// [R09] while locked the checksum field is refreshed every 21 master clock periods.
// [R10] the checksum is a crc-16 over the writable part of the map.
// [R11] polynomial 8005, msb first, zero seed, registers 00..1e each 24 bits msb first.
`timescale 1ns/1ps
`include "rmlc_defs.vh"
module rmlc_lock #(
  parameter SUM_PERIOD = `RMLC_SUM_PERIOD
) (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire        wr_en_in,
  input  wire [4:0]  wr_addr_in,
  input  wire [23:0] wr_data_in,
  input  wire        rd_en_in,
  input  wire [4:0]  rd_addr_in,
  output reg  [23:0] rd_data_out,
  output reg         rd_valid_out,
  input  wire        sum_irq_en_in,
  output wire        locked_out,
  output reg         sum_irq_out
);
  localparam        ST_IDLE   = 3'b001;
  localparam        ST_FILL   = 3'b010;
  localparam        ST_RUN    = 3'b100;
  localparam [31:0] PERIOD_M1 = SUM_PERIOD - 1; // tick counter is 5 bits, period up to 32

  reg  [7:0]  key_q;
  reg  [15:0] sum_q;
  reg  [15:0] acc_q;
  reg  [15:0] acc_d;
  reg  [15:0] done_q;
  reg  [15:0] ref_q;
  reg  [2:0]  state_q;
  reg  [4:0]  scan_q;
  reg  [4:0]  pos_q;
  reg  [4:0]  tick_q;
  reg         rd_sec_q;
  reg         rd_pend_q;
  wire [23:0] mem_rd;
  wire [23:0] mem_scan;
  wire        unlocked;
  wire        map_wr;
  wire        pass_end;
  wire        tick_end;

  // crc-16 step over one 24-bit word, msb first
  // [R11] poly 8005, msb first
  function [15:0] crc_word;
    input [15:0] crc;
    input [23:0] word;
    integer k;
    reg [15:0] c;
    begin
      c = crc;
      for (k = 23; k >= 0; k = k - 1)
        c = (c[15] ^ word[k]) ? ((c << 1) ^ `RMLC_CRC_POLY) : (c << 1);
      crc_word = c;
    end
  endfunction

  // lock state decoded from the key
  assign unlocked   = (key_q == `RMLC_KEY_UNLOCK);
  assign locked_out = ~unlocked;
  // [R02] map write gate
  // [R05] locked writes dropped
  assign map_wr = wr_en_in && unlocked && (wr_addr_in != `RMLC_SEC_ADDR);

  rmlc_map_mem #(
    .AW    (5),
    .DW    (24),
    .DEPTH (31)
  ) u_mem (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .wr_en_in      (map_wr),
    .wr_addr_in    (wr_addr_in),
    .wr_data_in    (wr_data_in),
    .rd_addr_in    (rd_addr_in),
    .rd_data_out   (mem_rd),
    .scan_addr_in  (scan_q),
    .scan_data_out (mem_scan)
  );

  // key register, always writable
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      key_q <= `RMLC_KEY_UNLOCK;
    else if (wr_en_in && (wr_addr_in == `RMLC_SEC_ADDR))
      key_q <= wr_data_in[`RMLC_KEY_HI:`RMLC_KEY_LO];
  end

  // wrap points of the word pipeline and the refresh counter
  assign pass_end = (pos_q == `RMLC_SUM_LAST);
  assign tick_end = (tick_q == PERIOD_M1[4:0]);

  // [R10] crc of fetched word
  // reseeded whenever the word in flight is the first of the map
  always @*
  begin
    acc_d = crc_word((pos_q == `RMLC_SUM_FIRST) ? `RMLC_CRC_SEED : acc_q, mem_scan);
  end

  // checksum sequencer: one map word per cycle, field refreshed every SUM_PERIOD cycles
  // a full pass takes 31 cycles, longer than the refresh period; the map is frozen
  // while locked, so each refresh publishes the last full pass and stays exact
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q     <= ST_IDLE;
      scan_q      <= `RMLC_SUM_FIRST;
      pos_q       <= `RMLC_SUM_FIRST;
      tick_q      <= 5'h00;
      acc_q       <= `RMLC_CRC_SEED;
      done_q      <= `RMLC_SUM_RESET;
      sum_q       <= `RMLC_SUM_RESET;
      ref_q       <= `RMLC_SUM_RESET;
      sum_irq_out <= 1'b0;
    end
    else if (unlocked)
    begin
      // [R03] field and interrupt cleared
      // [R04] no computation when open
      state_q     <= ST_IDLE;
      scan_q      <= `RMLC_SUM_FIRST;
      pos_q       <= `RMLC_SUM_FIRST;
      tick_q      <= 5'h00;
      acc_q       <= `RMLC_CRC_SEED;
      done_q      <= `RMLC_SUM_RESET;
      sum_q       <= `RMLC_SUM_RESET;
      ref_q       <= `RMLC_SUM_RESET;
      sum_irq_out <= 1'b0;
    end
    else
    begin
      // scan address walks 00..1e and wraps; pos_q names the word now in mem_scan
      scan_q <= (scan_q == `RMLC_SUM_LAST) ? `RMLC_SUM_FIRST : scan_q + 5'h01;
      pos_q  <= scan_q;
      // [R07] accumulate without stop
      acc_q  <= acc_d;
      // [R09] fixed refresh period
      tick_q <= tick_end ? 5'h00 : tick_q + 5'h01;
      case (state_q)
        ST_IDLE:
          state_q <= ST_FILL;
        ST_FILL:
        begin
          // first full pass sets the interrupt reference; no refresh before it
          if (pass_end)
          begin
            done_q  <= acc_d;
            ref_q   <= acc_d;
            state_q <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (pass_end)
            done_q <= acc_d;
          // [R07] publish, flag if enabled
          if (tick_end)
          begin
            sum_q <= done_q;
            if (sum_irq_en_in && (done_q != ref_q))
              sum_irq_out <= 1'b1;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // read path: one cycle after the strobe
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rd_sec_q  <= 1'b0;
      rd_pend_q <= 1'b0;
    end
    else
    begin
      rd_pend_q <= rd_en_in;
      rd_sec_q  <= (rd_addr_in == `RMLC_SEC_ADDR);
    end
  end

  // read data mux
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rd_data_out  <= 24'h000000;
      rd_valid_out <= 1'b0;
    end
    else
    begin
      rd_valid_out <= rd_pend_q;
      if (rd_pend_q)
      begin
        // [R01] security word layout
        if (rd_sec_q)
          rd_data_out <= {key_q, unlocked ? `RMLC_SUM_RESET : sum_q};
        // [R06] locked reads undefined
        else if (!unlocked)
          rd_data_out <= 24'hffffff;
        else
          rd_data_out <= mem_rd;
      end
    end
  end
endmodule

// >>> rmlc_lock_checker.sv
// port assertions for the register map lock block
// assumes binding onto rmlc_lock, one clock domain
`timescale 1ns/1ps
module rmlc_lock_checker (
  input wire        clk_in,
  input wire        rst_n_in,
  input wire        wr_en_in,
  input wire [4:0]  wr_addr_in,
  input wire [23:0] wr_data_in,
  input wire        rd_en_in,
  input wire [4:0]  rd_addr_in,
  input wire [23:0] rd_data_out,
  input wire        rd_valid_out,
  input wire        sum_irq_en_in,
  input wire        locked_out,
  input wire        sum_irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // read answer timing, security word content, lock state and interrupt cause
  AST_RD_LAT: assert property (rd_en_in |-> ##2 rd_valid_out)
    else $error("late read");
  AST_NO_SPUR: assert property (!$past(rd_en_in, 2) |-> !rd_valid_out)
    else $error("stray valid");
  AST_OPEN_WORD: assert property (rd_valid_out && $past(rd_addr_in, 2) == 5'h1f
    && !$past(locked_out) && !$past(locked_out, 2) |-> rd_data_out == 24'ha50000)
    else $error("open word");
  AST_KEY_SHUT: assert property (rd_valid_out && $past(rd_addr_in, 2) == 5'h1f
    && $past(locked_out) && $past(locked_out, 2) |-> rd_data_out[23:16] != 8'ha5)
    else $error("locked key");
  AST_SHUT_READ: assert property (rd_valid_out && $past(rd_addr_in, 2) != 5'h1f
    && $past(locked_out) |-> rd_data_out == 24'hffffff) else $error("locked read");
  AST_LOCK_WR: assert property (wr_en_in && wr_addr_in == 5'h1f |=>
    locked_out == ($past(wr_data_in[23:16]) != 8'ha5)) else $error("lock state");
  AST_IRQ_EN: assert property ($rose(sum_irq_out) |-> $past(sum_irq_en_in)
    && $past(locked_out)) else $error("irq cause");
  AST_IRQ_CLR: assert property (!locked_out && !$past(locked_out) |-> !sum_irq_out)
    else $error("irq open");
  // main scenarios reached
  cover property (rd_valid_out && locked_out);
  cover property ($rose(sum_irq_out));
  cover property ($fell(locked_out));
endmodule
bind rmlc_lock rmlc_lock_checker u_chk (.*);

// >>> rmlc_host.sv
// host side model issuing register writes and reads
// assumes reads answer two cycles after the taking edge
`timescale 1ns/1ps
module rmlc_host (
  input  wire        clk_in,
  output reg         wr_en_out = 1'b0,
  output reg  [4:0]  wr_addr_out = 5'h00,
  output reg  [23:0] wr_data_out = 24'h0,
  output reg         rd_en_out = 1'b0,
  output reg  [4:0]  rd_addr_out = 5'h00,
  input  wire [23:0] rd_data_in,
  input  wire        rd_valid_in
);
  task wr(input [4:0] a, input [23:0] d);
    @(posedge clk_in);
    wr_en_out <= 1'b1;
    wr_addr_out <= a;
    wr_data_out <= d;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    wr_addr_out <= ~a;
    wr_data_out <= ~d;
  endtask
  // one read, waits a bounded time for valid
  task rd(input [4:0] a, output [23:0] d);
    int i;
    @(posedge clk_in);
    rd_en_out <= 1'b1;
    rd_addr_out <= a;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
    rd_addr_out <= ~a;
    for (i = 0; i < 4 && rd_valid_in !== 1'b1; i++) @(posedge clk_in);
    // a missing answer returns unknowns so the caller's compare fails
    d = (rd_valid_in === 1'b1) ? rd_data_in : 24'hxxxxxx;
  endtask
endmodule

// >>> rmlc_lock_tb.sv
// self-checking bench for the register map lock block
// assumes the host model drives all bus traffic
`timescale 1ns/1ps
module rmlc_lock_tb;
  reg         clk_in = 1'b0;
  reg         rst_n_in = 1'b0;
  reg         irq_en = 1'b0;
  wire        we, re, rv, lk, irq;
  wire [4:0]  wa, ra;
  wire [23:0] wd, rdat;
  int         error_cnt = 0;
  int         n_tests = 0;
  int         cyc = 0;
  reg  [23:0] v, s1, s2;
  initial forever #5 clk_in = ~clk_in;
  rmlc_lock #(.SUM_PERIOD(21)) uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .wr_en_in(we),
    .wr_addr_in(wa), .wr_data_in(wd), .rd_en_in(re), .rd_addr_in(ra), .rd_data_out(rdat),
    .rd_valid_out(rv), .sum_irq_en_in(irq_en), .locked_out(lk), .sum_irq_out(irq));
  rmlc_host host (.clk_in(clk_in), .wr_en_out(we), .wr_addr_out(wa), .wr_data_out(wd),
    .rd_en_out(re), .rd_addr_out(ra), .rd_data_in(rdat), .rd_valid_in(rv));
  // compare one 24-bit result
  task chk(input [23:0] g, input [23:0] e);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // expected map checksum: poly 8005, zero seed, words 00..1e msb first, only word 03 set
  function [15:0] map_crc(input [23:0] w3);
    reg [15:0] c;
    reg [23:0] w;
    int        a;
    int        b;
    begin
      c = 16'h0000;
      for (a = 0; a < 31; a++)
      begin
        w = (a == 3) ? w3 : 24'h000000;
        for (b = 23; b >= 0; b--)
          c = (c[15] ^ w[b]) ? ((c << 1) ^ 16'h8005) : (c << 1);
      end
      map_crc = c;
    end
  endfunction
  // verdict and end of run
  task close_out;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      error_cnt++;
      close_out;
    end
  end
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    host.rd(5'h1f, v);
    chk(v, 24'ha50000);
    host.wr(5'h03, 24'h123456);
    host.rd(5'h03, v);
    chk(v, 24'h123456);
    host.wr(5'h1f, 24'h3c0000);
    host.rd(5'h03, v);
    chk(v, 24'hffffff);
    chk({23'h0, lk}, 24'h1);
    host.wr(5'h03, 24'h0);
    repeat (70) @(posedge clk_in);
    host.rd(5'h1f, s1);
    chk(s1, {8'h3c, map_crc(24'h123456)});
    repeat (18) @(posedge clk_in);
    host.rd(5'h1f, s2);
    chk(s2, {8'h3c, s1[15:0]});
    chk({23'h0, irq}, 24'h0);
    host.wr(5'h1f, 24'ha5ffff);
    host.rd(5'h03, v);
    chk(v, 24'h123456);
    host.rd(5'h1f, v);
    chk(v, 24'ha50000);
    irq_en <= 1'b1;
    host.wr(5'h1f, 24'h000000);
    repeat (100) @(posedge clk_in);
    chk({23'h0, irq}, 24'h0);
    host.rd(5'h1f, v);
    chk(v, {8'h00, map_crc(24'h123456)});
    host.wr(5'h1f, 24'ha50000);
    host.rd(5'h1f, v);
    chk(v, 24'ha50000);
    chk({23'h0, irq}, 24'h0);
    // mid-run reset while locked: key back to its open value, map writable
    host.wr(5'h1f, 24'h5a0000);
    rst_n_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    chk({23'h0, lk}, 24'h0);
    host.rd(5'h1f, v);
    chk(v, 24'ha50000);
    host.wr(5'h05, 24'habcdef);
    host.rd(5'h05, v);
    chk(v, 24'habcdef);
    close_out;
  end
endmodule
